// ---- src/hsp_ctrl.sv ----
// Purpose: Halt and clock-stop sequencer with wake logic and peripheral gating.
// Assumes: Core requests are one-cycle pulses; pins synchronous to clk_sys_in.
// Notes: Registers on AHB-Lite, zero wait states, always OKAY.
// Summary of operation
// - Halt ends when any selected condition true
// - Stop shuts down the crystal oscillator
// - No clock, nothing runs in stop
// - Supply-failure detector off during stop
// - Stop operand bits enable wake conditions
// - Wait half settle time, then resume
// - Enabled requested interrupt wakes stop regardless
// - Any enabled stop condition ends stop
// - Zero operand: only reset leaves stop
// - Stop is no-op during enable-pin rise/count
// - Readable enable-counter running flag
// - Peripherals run in halt, freeze in stop
// - Control registers partly reset on stop
// - Core held at instruction, system state kept
// - Serial stops as master in halt; ports in stop
// - Converter, counter, tone become ports in stop
// - Ports keep state during stop
// - Synthesizer disabled whenever enable pin low
// - Operand 1000B: interrupt acknowledge wakes, vectors
// - Operand 0001B: high key input wakes
// - Operand 0010B: timer carry wakes
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
module hsp_ctrl
	import hsp_pkg::*;
#(
	parameter int unsigned SETTLE_HALF_CYC = SETTLE_HALF_BASE_CYC
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic hreadyout_out,
	output logic hresp_out,
	output logic [31:0] hrdata_out,
	input wire logic halt_req_in,
	input wire logic stop_req_in,
	input wire logic [3:0] operand_in,
	input wire logic [3:0] key_input_port_in,
	input wire logic [3:0] key_adc_mode_in,
	input wire logic timer_carry_flag_in,
	input wire logic [IRQ_SRC_N-1:0] source_irq_enable_bit_in,
	input wire logic [IRQ_SRC_N-1:0] source_irq_request_bit_in,
	input wire logic global_irq_on_in,
	input wire logic enable_pin_in,
	input wire logic enable_counter_running_in,
	input wire logic enable_pin_reset_in,
	output logic core_hold_out,
	output logic resume_out,
	output logic irq_vector_take_out,
	output logic stop_nop_out,
	output logic osc_enable_out,
	output logic periph_run_out,
	output logic pfd_enable_out,
	output logic ctrl_reg_init_out,
	output logic serial_run_out,
	output logic alt_pins_gpio_out,
	output logic port_hold_out,
	output logic synth_enable_out,
	output logic enable_counter_running_flag_out
);
	hsp_state_t state_ff, nxt_state;
	logic [3:0] operand_ff;
	logic [3:0] cause_ff;
	logic [1:0] ctrl_ff;
	logic [1:0] settle_sel_ff;
	logic enable_pin_d_ff;
	logic addr_ok_ff, write_ff;
	logic [7:0] addr_ff;
	logic [3:0] cond_halt, cond_stop;
	logic wake_halt, wake_stop, stop_block, settle_load, settle_done, take_stop;
	logic [3:0] settle_mul;
	logic [SETTLE_W-1:0] settle_cnt;
	logic [31:0] nxt_rdata;

	// Halt conditions: interrupt needs acknowledge, hence global enable
	always_comb begin
		cond_halt = WAKE_NONE;
		cond_halt[WAKE_IRQ_BIT] = global_irq_on_in &&
			|(source_irq_enable_bit_in & source_irq_request_bit_in);
		cond_halt[WAKE_TIMER_BIT] = timer_carry_flag_in;
		cond_halt[WAKE_KEY_BIT] = |(key_input_port_in & ~key_adc_mode_in);
	end

	// Stop conditions: interrupt wakes whatever the global enable
	always_comb begin
		cond_stop = cond_halt;
		cond_stop[WAKE_IRQ_BIT] =
			|(source_irq_enable_bit_in & source_irq_request_bit_in);
	end

	assign wake_halt = |(operand_ff & cond_halt);
	assign wake_stop = |(operand_ff & cond_stop);
	assign stop_block = (enable_pin_in && !enable_pin_d_ff) || enable_counter_running_in;
	assign take_stop = (state_ff == ST_RUN) && stop_req_in && !stop_block;
	assign settle_load = (state_ff == ST_STOP) && wake_stop && !enable_pin_reset_in;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RUN: begin
				if (take_stop)
					nxt_state = ST_STOP;
				else if (halt_req_in && !stop_req_in)
					nxt_state = ST_HALT;
			end
			ST_HALT: begin
				if (enable_pin_reset_in || wake_halt)
					nxt_state = ST_RUN;
			end
			ST_STOP: begin
				if (enable_pin_reset_in)
					nxt_state = ST_RUN;
				else if (wake_stop)
					nxt_state = ST_SETTLE;
			end
			ST_SETTLE: begin
				if (enable_pin_reset_in || settle_done)
					nxt_state = ST_RUN;
			end
			default: nxt_state = ST_RUN;
		endcase
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in)
			state_ff <= ST_RUN;
		else
			state_ff <= nxt_state;
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in)
			operand_ff <= WAKE_NONE;
		else if (state_ff == ST_RUN && (halt_req_in || take_stop))
			operand_ff <= operand_in;
	end

	// Last wake cause for software diagnosis
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in)
			cause_ff <= WAKE_NONE;
		else if (state_ff == ST_HALT && wake_halt)
			cause_ff <= operand_ff & cond_halt;
		else if (settle_load)
			cause_ff <= operand_ff & cond_stop;
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		// Reset high: no false rise right after power-up with the pin high
		if (reset_in)
			enable_pin_d_ff <= 1'b1;
		else
			enable_pin_d_ff <= enable_pin_in;
	end

	always_comb begin
		case (settle_sel_ff)
			2'h0: settle_mul = SETTLE_MUL_0;
			2'h1: settle_mul = SETTLE_MUL_1;
			2'h2: settle_mul = SETTLE_MUL_2;
			default: settle_mul = SETTLE_MUL_3;
		endcase
	end
	assign settle_cnt = SETTLE_W'(SETTLE_HALF_CYC * settle_mul);

	hsp_settle_timer u_settle (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.load_in(settle_load),
		.count_in(settle_cnt),
		.done_out(settle_done)
	);

	// Event pulses to the core
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			resume_out <= 1'b0;
			irq_vector_take_out <= 1'b0;
			stop_nop_out <= 1'b0;
			ctrl_reg_init_out <= 1'b0;
		end else begin
			resume_out <= (state_ff == ST_HALT && wake_halt && !enable_pin_reset_in) ||
				(state_ff == ST_SETTLE && settle_done && !enable_pin_reset_in);
			irq_vector_take_out <= state_ff == ST_HALT && !enable_pin_reset_in &&
				operand_ff[WAKE_IRQ_BIT] && cond_halt[WAKE_IRQ_BIT];
			stop_nop_out <= state_ff == ST_RUN && stop_req_in && stop_block;
			ctrl_reg_init_out <= take_stop;
		end
	end

	// Power and gating levels follow the next state
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			core_hold_out <= 1'b0;
			osc_enable_out <= 1'b1;
			periph_run_out <= 1'b1;
			pfd_enable_out <= 1'b1;
			serial_run_out <= 1'b1;
			alt_pins_gpio_out <= 1'b0;
			port_hold_out <= 1'b0;
		end else begin
			core_hold_out <= nxt_state != ST_RUN;
			osc_enable_out <= nxt_state != ST_STOP;
			periph_run_out <= nxt_state == ST_RUN || nxt_state == ST_HALT;
			pfd_enable_out <= nxt_state != ST_STOP && nxt_state != ST_SETTLE;
			serial_run_out <= nxt_state == ST_RUN ||
				(nxt_state == ST_HALT && !ctrl_ff[CTRL_SER_MASTER_BIT]);
			alt_pins_gpio_out <= nxt_state == ST_STOP || nxt_state == ST_SETTLE;
			port_hold_out <= nxt_state == ST_STOP || nxt_state == ST_SETTLE;
		end
	end

	// Synthesizer gate: pin low wins over software, also in halt
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in)
			synth_enable_out <= 1'b0;
		else
			synth_enable_out <= enable_pin_in && ctrl_ff[CTRL_SYNTH_EN_BIT] &&
				(nxt_state == ST_RUN || nxt_state == ST_HALT);
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in)
			enable_counter_running_flag_out <= 1'b0;
		else
			enable_counter_running_flag_out <= enable_counter_running_in;
	end

	// AHB-Lite slave, zero wait states
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			addr_ok_ff <= 1'b0;
			write_ff <= 1'b0;
			addr_ff <= 8'h00;
		end else if (hready_in) begin
			addr_ok_ff <= hsel_in && htrans_in[1];
			write_ff <= hwrite_in;
			addr_ff <= haddr_in[7:0];
		end
	end

	// CTRL is reloaded with CTRL_RESET on stop entry, settle select kept; control state is not sampled during stop
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			ctrl_ff <= CTRL_RESET;
			settle_sel_ff <= SETTLE_RESET;
		end else if (take_stop) begin
			ctrl_ff <= CTRL_RESET;
		end else if (addr_ok_ff && write_ff) begin
			if (addr_ff == REG_CTRL_OFS)
				ctrl_ff <= hwdata_in[1:0];
			if (addr_ff == REG_SETTLE_OFS)
				settle_sel_ff <= hwdata_in[1:0];
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (haddr_in[7:0])
			REG_CTRL_OFS: nxt_rdata[1:0] = ctrl_ff;
			REG_SETTLE_OFS: nxt_rdata[1:0] = settle_sel_ff;
			REG_STATUS_OFS: begin
				nxt_rdata[1:0] = state_ff;
				nxt_rdata[STAT_CNT_RUN_BIT] = enable_counter_running_flag_out;
				nxt_rdata[STAT_CAUSE_LSB+:4] = cause_ff;
			end
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			hrdata_out <= 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			if (hready_in && hsel_in && htrans_in[1] && !hwrite_in)
				hrdata_out <= nxt_rdata;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end

	property p_halt_wake;
		@(posedge clk_sys_in) disable iff (reset_in)
		(state_ff == ST_HALT && wake_halt && !enable_pin_reset_in) |=>
			(state_ff == ST_RUN && resume_out && !core_hold_out);
	endproperty
	a_halt_wake: assert property (p_halt_wake) else $error("halt wake missed");

	property p_stop_osc;
		@(posedge clk_sys_in) disable iff (reset_in)
		take_stop |=> !osc_enable_out && !pfd_enable_out && ctrl_reg_init_out;
	endproperty
	a_stop_osc: assert property (p_stop_osc) else $error("stop entry wrong");

	property p_stop_nop;
		@(posedge clk_sys_in) disable iff (reset_in)
		(state_ff == ST_RUN && stop_req_in && enable_counter_running_in) |=>
			(state_ff != ST_STOP && stop_nop_out);
	endproperty
	a_stop_nop: assert property (p_stop_nop) else $error("stop not ignored");

	property p_zero_stays;
		@(posedge clk_sys_in) disable iff (reset_in)
		(state_ff == ST_STOP && operand_ff == WAKE_NONE && !enable_pin_reset_in) |=>
			state_ff == ST_STOP;
	endproperty
	a_zero_stays: assert property (p_zero_stays) else $error("zero operand woke");

	property p_stop_irq;
		@(posedge clk_sys_in) disable iff (reset_in)
		(state_ff == ST_STOP && operand_ff[WAKE_IRQ_BIT] && !enable_pin_reset_in &&
			|(source_irq_enable_bit_in & source_irq_request_bit_in)) |=> state_ff == ST_SETTLE;
	endproperty
	a_stop_irq: assert property (p_stop_irq) else $error("irq stop wake missed");

	property p_settle_hold;
		@(posedge clk_sys_in) disable iff (reset_in)
		$rose(state_ff == ST_SETTLE) |-> (!resume_out && core_hold_out) [*2];
	endproperty
	a_settle_hold: assert property (p_settle_hold) else $error("early resume");

	property p_synth_pin;
		@(posedge clk_sys_in) disable iff (reset_in)
		!enable_pin_in |=> !synth_enable_out;
	endproperty
	a_synth_pin: assert property (p_synth_pin) else $error("synth on, pin low");

	property p_stop_gate;
		@(posedge clk_sys_in) disable iff (reset_in)
		state_ff == ST_STOP |-> !periph_run_out && alt_pins_gpio_out && port_hold_out;
	endproperty
	a_stop_gate: assert property (p_stop_gate) else $error("stop gating wrong");

	property p_serial_master;
		@(posedge clk_sys_in) disable iff (reset_in)
		(state_ff == ST_HALT && ctrl_ff[CTRL_SER_MASTER_BIT]) |-> !serial_run_out;
	endproperty
	a_serial_master: assert property (p_serial_master) else $error("master serial ran");

	property p_cnt_flag;
		@(posedge clk_sys_in) disable iff (reset_in)
		enable_counter_running_in |=> enable_counter_running_flag_out;
	endproperty
	a_cnt_flag: assert property (p_cnt_flag) else $error("counter flag stale");

	c_halt_irq: cover property (@(posedge clk_sys_in) irq_vector_take_out);
	c_stop_settle: cover property (@(posedge clk_sys_in)
		state_ff == ST_SETTLE ##1 state_ff == ST_RUN);
	c_stop_nop: cover property (@(posedge clk_sys_in) stop_nop_out);
endmodule // hsp_ctrl

// ---- src/hsp_pkg.sv ----
// Purpose: Shared constants for the halt and clock-stop power controller.
// Assumes: 50 MHz system clock, AHB-Lite register access.
// Notes: Settle counts of 250000 to 2500000 cycles are overridable at the top.
package hsp_pkg;
	localparam int unsigned CLK_MHZ = 50;
	// Nominal crystal rate whose oscillator is gated off in clock-stop
	localparam int unsigned XTAL_KHZ = 4500;
	// Half of the shortest oscillator_settle_time (10 ms), in microseconds
	localparam int unsigned SETTLE_HALF_BASE_US = 5000;
	localparam int unsigned SETTLE_HALF_BASE_CYC = SETTLE_HALF_BASE_US * CLK_MHZ;
	localparam int unsigned SETTLE_W = 32;
	// Multipliers for the 10, 20, 50, 100 ms selections
	localparam logic [3:0] SETTLE_MUL_0 = 4'h1;
	localparam logic [3:0] SETTLE_MUL_1 = 4'h2;
	localparam logic [3:0] SETTLE_MUL_2 = 4'h5;
	localparam logic [3:0] SETTLE_MUL_3 = 4'hA;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL_OFS = 8'h00;
	localparam logic [7:0] REG_SETTLE_OFS = 8'h04;
	localparam logic [7:0] REG_STATUS_OFS = 8'h08;
	// CTRL fields
	localparam int unsigned CTRL_SYNTH_EN_BIT = 0;
	localparam int unsigned CTRL_SER_MASTER_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	localparam logic [1:0] SETTLE_RESET = 2'h3;
	// Operand bits shared by halt and stop
	localparam int unsigned WAKE_KEY_BIT = 0;
	localparam int unsigned WAKE_TIMER_BIT = 1;
	localparam int unsigned WAKE_IRQ_BIT = 3;
	localparam logic [3:0] WAKE_NONE = 4'h0;
	localparam int unsigned IRQ_SRC_N = 12;
	// STATUS fields
	localparam int unsigned STAT_CNT_RUN_BIT = 2;
	localparam int unsigned STAT_CAUSE_LSB = 4;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_STOP, ST_SETTLE} hsp_state_t;
endpackage

// ---- src/hsp_settle_timer.sv ----
// Purpose: Down-counter for the oscillator settling wait after a stop wake.
// Assumes: load pulses once per wake; count held in cycles.
// Notes: done is a one-cycle registered pulse.
`timescale 1ns/10ps
module hsp_settle_timer
	import hsp_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic load_in,
	input wire logic [SETTLE_W-1:0] count_in,
	output logic done_out
);
	logic [SETTLE_W-1:0] cnt_ff;
	logic busy_ff;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_ff <= '0;
			busy_ff <= 1'b0;
		end else if (load_in) begin
			cnt_ff <= count_in;
			busy_ff <= 1'b1;
		end else if (busy_ff) begin
			cnt_ff <= cnt_ff - 1'b1;
			if (cnt_ff <= 1)
				busy_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in)
			done_out <= 1'b0;
		else
			done_out <= busy_ff && !load_in && (cnt_ff <= 1);
	end
endmodule // hsp_settle_timer

// ---- sim/hsp_core_model.sv ----
// Purpose: Core stand-in that issues halt and stop requests.
// Assumes: issue is entered just after a rising edge.
// Notes: Operand shows a flipped value outside a request.
`timescale 1ns/10ps
module hsp_core_model (
	input wire logic clk_sys_in,
	input wire logic resume_in,
	input wire logic irq_vector_take_in,
	output logic halt_req_out,
	output logic stop_req_out,
	output logic [3:0] operand_out,
	output int resumes_out,
	output int vectors_out
);
	initial begin
		halt_req_out = 1'b0;
		stop_req_out = 1'b0;
		operand_out = 4'hF;
		resumes_out = 0;
		vectors_out = 0;
	end
	task issue(input logic is_stop, input logic [3:0] op);
		stop_req_out <= is_stop;
		halt_req_out <= !is_stop;
		operand_out <= op;
		@(posedge clk_sys_in);
		stop_req_out <= 1'b0;
		halt_req_out <= 1'b0;
		operand_out <= ~op;
	endtask
	// Vector and plain wake arrive in the same cycle; software polls the rest itself
	always @(posedge clk_sys_in) begin
		if (resume_in === 1'b1)
			resumes_out <= resumes_out + 1;
		if (irq_vector_take_in === 1'b1)
			vectors_out <= vectors_out + 1;
	end
endmodule // hsp_core_model

// ---- sim/tb_halt_stop_power_controller.sv ----
// Purpose: Self-checking bench for the halt and clock-stop controller.
// Assumes: Settle half time shortened to 4 cycles.
// Notes: Inputs change by non-blocking assignment at rising edges.
`timescale 1ns/10ps
module tb_halt_stop_power_controller
	import hsp_pkg::*;
();
	localparam int unsigned HALF = 4;
	logic ck = 1'b0;
	logic rs = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hrdy, hresp, halt_r, stop_r;
	logic [31:0] hrdata;
	logic [3:0] op, key = 4'h0, adc = 4'h0;
	logic carry = 1'b0, gie = 1'b0, pin = 1'b1, cnt = 1'b0, prst = 1'b0;
	logic [11:0] ien = 12'h0, irq = 12'h0;
	logic hold, res, vec, nop, osc, prun, pfd, init, ser, gpio, phold, synth, cflag;
	int resumes, vectors;
	int n_mismatch = 0;
	int num_checks = 0;
	initial forever #10 ck = ~ck;
	hsp_ctrl #(.SETTLE_HALF_CYC(HALF)) dut (.clk_sys_in(ck), .reset_in(rs), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
		.hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp),
		.hrdata_out(hrdata), .halt_req_in(halt_r), .stop_req_in(stop_r), .operand_in(op),
		.key_input_port_in(key), .key_adc_mode_in(adc), .timer_carry_flag_in(carry),
		.source_irq_enable_bit_in(ien), .source_irq_request_bit_in(irq),
		.global_irq_on_in(gie), .enable_pin_in(pin), .enable_counter_running_in(cnt),
		.enable_pin_reset_in(prst), .core_hold_out(hold), .resume_out(res),
		.irq_vector_take_out(vec), .stop_nop_out(nop), .osc_enable_out(osc),
		.periph_run_out(prun), .pfd_enable_out(pfd), .ctrl_reg_init_out(init),
		.serial_run_out(ser), .alt_pins_gpio_out(gpio), .port_hold_out(phold),
		.synth_enable_out(synth), .enable_counter_running_flag_out(cflag));
	hsp_core_model core (.clk_sys_in(ck), .resume_in(res), .irq_vector_take_in(vec),
		.halt_req_out(halt_r), .stop_req_out(stop_r), .operand_out(op),
		.resumes_out(resumes), .vectors_out(vectors));
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ck);
	endtask
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge ck);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		@(posedge ck);
		while (hrdy !== 1'b1) @(posedge ck);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge ck);
		while (hrdy !== 1'b1) @(posedge ck);
		rd = hrdata;
	endtask
	// Counts edges until the resume pulse shows
	task wait_res(output int n);
		n = 0;
		do begin
			@(posedge ck);
			#1 n++;
		end while (res !== 1'b1 && n < 100);
	endtask
	task t_reset;
		logic [31:0] d;
		chk("hreadyout", hrdy, 1'b1);
		chk("hresp", hresp, 1'b0);
		chk("osc", osc, 1'b1);
		chk("hold", hold, 1'b0);
		bus(1'b0, REG_CTRL_OFS, 32'h0, d);
		chk("ctrl", d, {30'h0, CTRL_RESET});
		bus(1'b0, REG_SETTLE_OFS, 32'h0, d);
		chk("settle", d, {30'h0, SETTLE_RESET});
		bus(1'b1, REG_STATUS_OFS, 32'h3, d);
		bus(1'b0, 8'h0C, 32'h0, d);
		chk("unmapped", d, 32'h0);
		bus(1'b0, REG_STATUS_OFS, 32'h0, d);
		chk("state run", d[1:0], 2'h0);
	endtask
	task t_halt_multi;
		int n;
		logic [31:0] d;
		@(posedge ck);
		core.issue(1'b0, 4'hB);
		#1 chk("hold", hold, 1'b1);
		chk("prun", prun, 1'b1);
		chk("slave serial", ser, 1'b1);
		bus(1'b0, REG_STATUS_OFS, 32'h0, d);
		chk("state halt", d[1:0], 2'h1);
		chk("synth halt", synth, 1'b1);
		@(posedge ck);
		pin <= 1'b0;
		cyc(3);
		#1 chk("synth", synth, 1'b0);
		@(posedge ck);
		pin <= 1'b1;
		carry <= 1'b1;
		wait_res(n);
		chk("carry wake", n <= 2, 1'b1);
		@(posedge ck);
		carry <= 1'b0;
	endtask
	task t_halt_key;
		int n;
		@(posedge ck);
		adc <= 4'h4;
		key <= 4'h4;
		core.issue(1'b0, 4'h1);
		cyc(8);
		#1 chk("adc key", hold, 1'b1);
		@(posedge ck);
		key <= 4'h5;
		wait_res(n);
		chk("key wake", n <= 2, 1'b1);
		@(posedge ck);
		core.issue(1'b0, 4'h1);
		wait_res(n);
		chk("entry wake", n <= 2, 1'b1);
		@(posedge ck);
		key <= 4'h0;
		adc <= 4'h0;
	endtask
	task t_halt_irq;
		int n, v;
		logic [31:0] d;
		bus(1'b1, REG_CTRL_OFS, 32'h3, d);
		@(posedge ck);
		v = vectors;
		gie <= 1'b1;
		ien <= 12'h020;
		core.issue(1'b0, 4'h8);
		cyc(6);
		#1 chk("master serial", ser, 1'b0);
		chk("no request", hold, 1'b1);
		@(posedge ck);
		irq <= 12'h020;
		wait_res(n);
		cyc(1);
		#1 chk("vector", vectors, v + 1);
		@(posedge ck);
		irq <= 12'h0;
		gie <= 1'b0;
	endtask
	task t_stop(input logic [3:0] s, input logic [1:0] src);
		int n, v;
		logic [31:0] d;
		bus(1'b1, REG_SETTLE_OFS, 32'h0, d);
		bus(1'b1, REG_CTRL_OFS, 32'h2, d);
		@(posedge ck);
		v = vectors;
		key <= (src == 2'h1) ? 4'h0 : 4'hF;
		core.issue(1'b1, s);
		#1 chk("osc", osc, 1'b0);
		chk("prun", prun, 1'b0);
		chk("pfd", pfd, 1'b0);
		chk("init", init, 1'b1);
		chk("ser", ser, 1'b0);
		chk("gpio", gpio, 1'b1);
		chk("ports", phold, 1'b1);
		cyc(10);
		#1 chk("still stopped", hold, 1'b1);
		@(posedge ck);
		// Source 0 timer carry, 1 key port, 2 matching enabled interrupt
		case (src)
			2'h0: carry <= 1'b1;
			2'h1: key <= 4'h2;
			default: irq <= 12'h003;
		endcase
		wait_res(n);
		chk("settle", n >= HALF && n <= HALF + 6, 1'b1);
		chk("osc back", osc, 1'b1);
		chk("no vector", vectors, v);
		bus(1'b0, REG_CTRL_OFS, 32'h0, d);
		chk("ctrl init", d, {30'h0, CTRL_RESET});
		@(posedge ck);
		key <= 4'h0;
		carry <= 1'b0;
		ien <= 12'h0;
		irq <= 12'h0;
	endtask
	task t_stop_irq;
		@(posedge ck);
		ien <= 12'h001;
		irq <= 12'h002;
		gie <= 1'b0;
		t_stop(4'h8, 2'h2);
	endtask
	task t_stop_zero;
		int r;
		@(posedge ck);
		key <= 4'hF;
		carry <= 1'b1;
		core.issue(1'b1, 4'h0);
		cyc(20);
		#1 chk("zero operand", hold, 1'b1);
		r = resumes;
		@(posedge ck);
		prst <= 1'b1;
		@(posedge ck);
		prst <= 1'b0;
		key <= 4'h0;
		carry <= 1'b0;
		cyc(2);
		#1 chk("reset release", hold, 1'b0);
		chk("no resume", resumes, r);
	endtask
	task t_stop_nop;
		@(posedge ck);
		cnt <= 1'b1;
		cyc(2);
		#1 chk("cnt flag", cflag, 1'b1);
		@(posedge ck);
		core.issue(1'b1, 4'h2);
		#1 chk("nop cnt", nop, 1'b1);
		chk("no stop", osc, 1'b1);
		@(posedge ck);
		cnt <= 1'b0;
		pin <= 1'b0;
		cyc(3);
		@(posedge ck);
		pin <= 1'b1;
		core.issue(1'b1, 4'h2);
		#1 chk("nop rise", nop, 1'b1);
		chk("hold", hold, 1'b0);
		cyc(2);
		#1 chk("cnt flag off", cflag, 1'b0);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		cyc(2);
		rs <= 1'b0;
		t_reset;
		t_halt_multi;
		t_halt_key;
		t_halt_irq;
		t_stop(4'h2, 2'h0);
		t_stop(4'hB, 2'h1);
		t_stop_irq;
		t_stop_zero;
		t_stop_nop;
		close_out;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		cyc(5000);
		n_mismatch++;
		close_out;
	end
endmodule // tb_halt_stop_power_controller
